//--- bab_pkg.sv
// Constants for the byte ALU block: register map, field layout, opcodes.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package bab_pkg;

  // ********************************************************
  // Register map (byte addresses)
  // ********************************************************
  localparam logic [9:0] ADDR_ACC    = 10'h000;
  localparam logic [9:0] ADDR_STATUS = 10'h004;
  localparam logic [9:0] ADDR_EXEC   = 10'h008;
  localparam int         MEM_SEL_BIT = 9;
  localparam int         MEM_IDX_LO  = 2;
  localparam int         MEM_IDX_HI  = 8;

  // ********************************************************
  // Status bits
  // ********************************************************
  localparam int ST_CARRY  = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_NULL   = 2;
  localparam int ST_SKIP   = 3;
  localparam logic [3:0] STATUS_RST = 4'h0;

  // ********************************************************
  // Exec word fields
  // ********************************************************
  localparam int EX_OP_LO   = 0;
  localparam int EX_OP_HI   = 2;
  localparam int EX_DEST    = 3;
  localparam int EX_BIT_LO  = 4;
  localparam int EX_BIT_HI  = 6;
  localparam int EX_ADDR_LO = 8;
  localparam int EX_ADDR_HI = 14;

  localparam logic       DEST_ACC = 1'b0;
  localparam logic       DEST_REG = 1'b1;
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [4:0] NIBBLE_MAX = 5'h0F;

  typedef enum logic [2:0] {
    OP_AND_ACC_REG = 3'h0,
    OP_SUM_ACC_REG = 3'h1,
    OP_SUM_CARRY   = 3'h2,
    OP_ASR_REG     = 3'h3,
    OP_CLEAR_BIT   = 3'h4,
    OP_TEST_SKIP   = 3'h5,
    OP_NO_OP       = 3'h6
  } bab_op_type;

endpackage

//--- bab_alu_if.sv
// Interface between the byte ALU control and its combinational datapath.
// Assumes both ends share one clock domain; no timing of its own.
`timescale 1ns/1ps
interface bab_alu_if;
  logic [7:0]          acc;
  logic [7:0]          opnd;
  logic                carry_in;
  bab_pkg::bab_op_type op;
  logic [2:0]          bit_sel;
  logic [7:0]          result;
  logic                carry_out;
  logic                nibble_out;
  logic                null_out;
  logic                upd_carry;
  logic                upd_nibble;
  logic                upd_null;
  logic                writes;
  logic                to_reg_only;
  logic                skip;

  modport ctrl (output acc, opnd, carry_in, op, bit_sel,
                input result, carry_out, nibble_out, null_out, upd_carry,
                upd_nibble, upd_null, writes, to_reg_only, skip);
  modport alu  (input acc, opnd, carry_in, op, bit_sel,
                output result, carry_out, nibble_out, null_out, upd_carry,
                upd_nibble, upd_null, writes, to_reg_only, skip);
endinterface

//--- bab_alu.sv
// Combinational datapath of the byte ALU.
// Assumes operands are stable for the cycle in which the control fires.
`timescale 1ns/1ps
module bab_alu
(
  bab_alu_if.alu io
);

  logic [8:0] sum9;
  logic [4:0] sum5;

  always_comb
  begin
    sum9          = {1'b0, io.acc} + {1'b0, io.opnd};
    sum5          = {1'b0, io.acc[3:0]} + {1'b0, io.opnd[3:0]};
    io.result     = bab_pkg::BYTE_ZERO;
    io.carry_out  = 1'b0;
    io.upd_carry  = 1'b0;
    io.upd_nibble = 1'b0;
    io.upd_null   = 1'b0;
    io.writes     = 1'b1;
    io.to_reg_only = 1'b0;
    io.skip       = 1'b0;
    unique case (io.op)
      bab_pkg::OP_AND_ACC_REG:
      begin
        io.result   = io.acc & io.opnd;                  // see RULE_01
        io.upd_null = 1'b1;
      end
      bab_pkg::OP_SUM_ACC_REG, bab_pkg::OP_SUM_CARRY:
      begin
        if (io.op == bab_pkg::OP_SUM_CARRY)
        begin
          sum9 = sum9 + {8'h00, io.carry_in};            // see RULE_04
          sum5 = sum5 + {4'h0, io.carry_in};
        end
        io.result     = sum9[7:0];                       // see RULE_03
        io.carry_out  = sum9[8];                         // see RULE_10
        io.upd_carry  = 1'b1;
        io.upd_nibble = 1'b1;
        io.upd_null   = 1'b1;
      end
      bab_pkg::OP_ASR_REG:
      begin
        io.result    = {io.opnd[7], io.opnd[7:1]};       // see RULE_05 see RULE_06
        io.carry_out = io.opnd[0];                       // see RULE_05
        io.upd_carry = 1'b1;
        io.upd_null  = 1'b1;
      end
      bab_pkg::OP_CLEAR_BIT:
      begin
        io.result = io.opnd;
        io.result[io.bit_sel] = 1'b0;                    // see RULE_07
        io.to_reg_only = 1'b1;
      end
      bab_pkg::OP_TEST_SKIP:
      begin
        io.writes = 1'b0;
        io.skip   = ~io.opnd[io.bit_sel];                // see RULE_08 see RULE_09
      end
      default:
      begin
        io.writes = 1'b0;
      end
    endcase
    io.nibble_out = sum5 > bab_pkg::NIBBLE_MAX;          // see RULE_10
    io.null_out   = io.result == bab_pkg::BYTE_ZERO;     // see RULE_10
  end

endmodule

//--- bab_byte_alu.sv
// Byte ALU with accumulator, status flags and 128-byte register file.
// Assumes an Avalon-MM master with waitrequest on ref_clk.
//
// Function
// RULE_01 - The and operation ANDs the accumulator with register f (0..127) and updates only the null flag.
// RULE_02 - A destination bit of 0 sends the result to the accumulator, 1 back to register f.
// RULE_03 - The sum operation adds accumulator and register and updates carry, nibble and null flags.
// RULE_04 - The sum with carry-in also adds the carry flag and updates carry, nibble and null flags.
// RULE_05 - The arithmetic shift right moves bits 7:1 to 6:0, bit 0 to carry, updating carry and null.
// RULE_06 - During the arithmetic shift right the result keeps the source bit 7.
// RULE_07 - Clearing a bit zeroes bit b (0..7) of register f, keeps the rest and touches no flag.
// RULE_08 - Testing a bit that is one lets the next instruction run and changes no flag.
// RULE_09 - Testing a bit that is zero turns the next instruction into a no-operation, two cycles in all.
// RULE_10 - Null is set on a zero result; carry and nibble flags are carries out of bits 7 and 3.
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module bab_byte_alu
#(
  parameter int MEM_DEPTH = 128
)
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest
);

  // ********************************************************
  // State
  // ********************************************************
  logic [7:0]  acc;
  logic [3:0]  status;
  logic        ack;
  logic [7:0]  mem [MEM_DEPTH];
  logic [7:0]  next_acc;
  logic [3:0]  next_status;
  logic        next_ack;
  logic [31:0] next_readdata;
  logic        mem_we;
  logic [6:0]  mem_wa;
  logic [7:0]  mem_wd;

  logic        fire;
  logic        exec_fire;
  logic        is_mem;
  logic [6:0]  bus_idx;
  logic [6:0]  ex_addr;
  logic        ex_dest;
  logic [7:0]  opnd;

  bab_alu_if alu_bus();

  bab_alu u_alu
  (
    .io (alu_bus.alu)
  );

  assign fire      = (read | write) & ack;
  assign exec_fire = fire & write & (address == bab_pkg::ADDR_EXEC);
  assign is_mem    = address[bab_pkg::MEM_SEL_BIT];
  assign bus_idx   = address[bab_pkg::MEM_IDX_HI:bab_pkg::MEM_IDX_LO];
  assign ex_addr   = writedata[bab_pkg::EX_ADDR_HI:bab_pkg::EX_ADDR_LO];
  assign ex_dest   = writedata[bab_pkg::EX_DEST];
  assign opnd      = mem[ex_addr];

  // Answer one cycle after the request is seen
  assign waitrequest = (read | write) & ~ack;

  // ********************************************************
  // Datapath hookup
  // ********************************************************
  always_comb
  begin
    alu_bus.acc      = acc;
    alu_bus.opnd     = opnd;
    alu_bus.carry_in = status[bab_pkg::ST_CARRY];
    alu_bus.op       = bab_pkg::bab_op_type'(writedata[bab_pkg::EX_OP_HI:bab_pkg::EX_OP_LO]);
    alu_bus.bit_sel  = writedata[bab_pkg::EX_BIT_HI:bab_pkg::EX_BIT_LO];
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb
  begin
    next_acc      = acc;
    next_status   = status;
    next_ack      = (read | write) & ~ack;
    next_readdata = readdata;
    mem_we        = 1'b0;
    mem_wa        = bus_idx;
    mem_wd        = writedata[7:0];
    if ((read | write) & ~ack)
    begin
      next_readdata = '0;
      if (is_mem)
        next_readdata = {24'h000000, mem[bus_idx]};
      else if (address == bab_pkg::ADDR_ACC)
        next_readdata = {24'h000000, acc};
      else if (address == bab_pkg::ADDR_STATUS)
        next_readdata = {28'h0000000, status};
    end
    if (fire & write)
    begin
      if (is_mem)
        mem_we = 1'b1;
      else if (address == bab_pkg::ADDR_ACC)
        next_acc = writedata[7:0];
      else if (address == bab_pkg::ADDR_STATUS)
        next_status = writedata[3:0];
      else if (exec_fire)
      begin
        if (status[bab_pkg::ST_SKIP])
          // Fetched instruction discarded, runs as no-operation
          next_status[bab_pkg::ST_SKIP] = 1'b0;                    // see RULE_09
        else
        begin
          if (alu_bus.writes)
          begin
            if (alu_bus.to_reg_only | (ex_dest == bab_pkg::DEST_REG))
            begin
              mem_we = 1'b1;                                       // see RULE_02
              mem_wa = ex_addr;
              mem_wd = alu_bus.result;
            end
            else
              next_acc = alu_bus.result;                           // see RULE_02
          end
          if (alu_bus.upd_carry)
            next_status[bab_pkg::ST_CARRY] = alu_bus.carry_out;    // see RULE_10
          if (alu_bus.upd_nibble)
            next_status[bab_pkg::ST_NIBBLE] = alu_bus.nibble_out;  // see RULE_10
          if (alu_bus.upd_null)
            next_status[bab_pkg::ST_NULL] = alu_bus.null_out;      // see RULE_10
          next_status[bab_pkg::ST_SKIP] = alu_bus.skip;            // see RULE_09
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc      <= bab_pkg::ACC_RST;
      status   <= bab_pkg::STATUS_RST;
      ack      <= 1'b0;
      readdata <= '0;
    end
    else
    begin
      acc      <= next_acc;
      status   <= next_status;
      ack      <= next_ack;
      readdata <= next_readdata;
    end
  end

  // Memory has no reset; contents are software's to load
  always_ff @(posedge ref_clk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic run;
  logic [2:0] wop;
  assign run = exec_fire & ~status[bab_pkg::ST_SKIP];
  assign wop = writedata[bab_pkg::EX_OP_HI:bab_pkg::EX_OP_LO];

  sequence s_test_low;
    run && wop == 3'h5 && !opnd[writedata[bab_pkg::EX_BIT_HI:bab_pkg::EX_BIT_LO]];
  endsequence
  // Next exec while a skip is pending is the one that gets discarded
  sequence s_discard;
    exec_fire && status[bab_pkg::ST_SKIP];
  endsequence

  a_and_to_acc: assert property ( // see RULE_01
    run && wop == 3'h0 && !ex_dest |=> acc == ($past(acc) & $past(opnd))
      && status[bab_pkg::ST_CARRY] == $past(status[bab_pkg::ST_CARRY])
      && status[bab_pkg::ST_NIBBLE] == $past(status[bab_pkg::ST_NIBBLE]))
    else $error("and result or flags wrong");
  a_dest_reg: assert property ( // see RULE_02
    run && wop == 3'h1 && ex_dest |=> acc == $past(acc)
      && mem[$past(ex_addr)] == 8'($past(acc) + $past(opnd)))
    else $error("result not written back to register");
  a_sum_carry: assert property ( // see RULE_03
    run && wop == 3'h1 |=> status[bab_pkg::ST_CARRY]
      == ((9'($past(acc)) + 9'($past(opnd))) > 9'h0FF)
      && status[bab_pkg::ST_NIBBLE]
      == ((5'($past(acc[3:0])) + 5'($past(opnd[3:0]))) > 5'h0F))
    else $error("sum carry wrong");
  a_sum_cin: assert property ( // see RULE_04
    run && wop == 3'h2 && !ex_dest |=> acc
      == 8'($past(acc) + $past(opnd) + 8'($past(status[bab_pkg::ST_CARRY]))))
    else $error("sum with carry-in wrong");
  a_asr_value: assert property ( // see RULE_05
    run && wop == 3'h3 && !ex_dest |=> acc == {$past(opnd[7]), $past(opnd[7:1])}
      && status[bab_pkg::ST_CARRY] == $past(opnd[0]))
    else $error("shift right wrong");
  a_asr_sign: assert property ( // see RULE_06
    run && wop == 3'h3 && !ex_dest |=> acc[7] == $past(opnd[7]))
    else $error("shift lost sign");
  a_clear_bit: assert property ( // see RULE_07
    run && wop == 3'h4 |=> status == $past(status)
      && mem[$past(ex_addr)][$past(writedata[6:4])] == 1'b0 && acc == $past(acc))
    else $error("bit clear wrong");
  a_test_high: assert property ( // see RULE_08
    run && wop == 3'h5 && opnd[writedata[6:4]] |=> status == $past(status))
    else $error("test of set bit changed state");
  a_skip_set: assert property ( // see RULE_09
    s_test_low |=> status[bab_pkg::ST_SKIP] && acc == $past(acc))
    else $error("zero bit test did not arm skip");
  a_skip_nop: assert property ( // see RULE_09
    s_discard |=> acc == $past(acc) && !status[bab_pkg::ST_SKIP]
      && status[2:0] == $past(status[2:0]) && mem[$past(ex_addr)] == $past(opnd))
    else $error("skipped instruction was executed");
  a_null_flag: assert property ( // see RULE_10
    run && (wop == 3'h0 || wop == 3'h1) |=>
      status[bab_pkg::ST_NULL] == (($past(wop) == 3'h0)
        ? (($past(acc) & $past(opnd)) == 8'h00)
        : (8'($past(acc) + $past(opnd)) == 8'h00)))
    else $error("null flag wrong");

endmodule

//--- bab_host_model.sv
// Avalon-MM master standing in for the decoder, sequencer and data memory.
// Assumes a slave that drops waitrequest before the bench timeout.
`timescale 1ns/1ps
module bab_host_model
(
  input  wire logic        ref_clk,
  output logic      [9:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  // ********************************************************
  // Bus transfer
  // ********************************************************
  initial
  begin
    address = 10'h3FF;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
  end

  // Waitrequest sampled at the rising edge itself; that edge completes the transfer
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    @(posedge ref_clk);
    while (waitrequest)
      @(posedge ref_clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // Released lines invert so a stale value is never mistaken for a request
    address <= ~a;
    writedata <= ~d;
  endtask
endmodule

//--- byte_alu_bit_ops_bench.sv
// Self-checking bench for the byte ALU, driven over Avalon-MM.
// Assumes the register map and exec word layout of the package.
`timescale 1ns/1ps
module byte_alu_bit_ops_bench;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [9:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [7:0]  m_acc;
  logic [3:0]  m_st;
  logic [7:0]  m_mem [128];
  logic [31:0] q;
  logic [31:0] r;
  logic [31:0] s;

  always #5 ref_clk = ~ref_clk;

  bab_byte_alu u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  bab_host_model u_host (.ref_clk(ref_clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

  // ********************************************************
  // Expectation and checking
  // ********************************************************
  // Returns {status, acc, register}
  function automatic logic [19:0] expect_op(input logic [7:0] a, input logic [7:0] v,
      input logic [3:0] st, input logic [2:0] op, input logic d, input logic [2:0] b);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] res;
    sum = {1'b0, a} + {1'b0, v} + ((op == 3'h2) ? {8'h0, st[0]} : 9'h0);
    nib = {1'b0, a[3:0]} + {1'b0, v[3:0]} + ((op == 3'h2) ? {4'h0, st[0]} : 5'h0);
    res = 8'h0;
    if (st[3])
      return {1'b0, st[2:0], a, v};
    case (op)
      3'h0: res = a & v;
      3'h1, 3'h2:
      begin
        res = sum[7:0];
        st[1:0] = {nib[4], sum[8]};
      end
      3'h3:
      begin
        res = {v[7], v[7:1]};
        st[0] = v[0];
      end
      3'h4: return {st, a, v & ~(8'h01 << b)};
      3'h5: return {~v[b], st[2:0], a, v};
      default: return {st, a, v};
    endcase
    st[2] = (res == 8'h00);
    return d ? {st, a, res} : {st, res, v};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask

  task automatic close_out;
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic setv(input logic [7:0] a, input logic [7:0] v, input logic [3:0] st,
                      input logic [6:0] f);
    wr(bab_pkg::ADDR_ACC, {24'h0, a});
    wr(bab_pkg::ADDR_STATUS, {28'h0, st});
    wr({1'b1, f, 2'b00}, {24'h0, v});
    {m_acc, m_st, m_mem[f]} = {a, st, v};
  endtask

  task automatic run_op(input logic [2:0] op, input logic d, input logic [2:0] b,
                        input logic [6:0] f);
    logic [19:0] e;
    e = expect_op(m_acc, m_mem[f], m_st, op, d, b);
    wr(bab_pkg::ADDR_EXEC, {17'h0, f, 1'b0, b, d, op});
    {m_st, m_acc, m_mem[f]} = e;
    rd_chk(bab_pkg::ADDR_ACC, {24'h0, m_acc});
    rd_chk(bab_pkg::ADDR_STATUS, {28'h0, m_st});
    rd_chk({1'b1, f, 2'b00}, {24'h0, m_mem[f]});
  endtask

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      close_out;
    end
  end

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial
  begin
    r = $urandom(32'h82581C2B);
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 128; i++)
    begin
      r = $urandom;
      wr({1'b1, i[6:0], 2'b00}, r);
      m_mem[i] = r[7:0];
    end
    wr(bab_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    wr(bab_pkg::ADDR_ACC, 32'hFFFFFFFF);
    wr(10'h00C, 32'h0000005A);
    rd_chk(bab_pkg::ADDR_STATUS, 32'h0000000F);
    rd_chk(bab_pkg::ADDR_ACC, 32'h000000FF);
    rd_chk(10'h00C, 32'h0);
    rd_chk(bab_pkg::ADDR_EXEC, 32'h0);
    // Corners: full carry, carry-in rollover, sign fill, skip then discard
    setv(8'hFF, 8'h01, 4'h0, 7'h7F);
    run_op(3'h1, 1'b0, 3'h0, 7'h7F);
    setv(8'h0F, 8'hF0, 4'h1, 7'h00);
    run_op(3'h2, 1'b1, 3'h0, 7'h00);
    setv(8'h00, 8'h81, 4'h0, 7'h05);
    run_op(3'h3, 1'b1, 3'h0, 7'h05);
    setv(8'h3C, 8'h7F, 4'h0, 7'h09);
    run_op(3'h5, 1'b0, 3'h7, 7'h09);
    run_op(3'h1, 1'b0, 3'h0, 7'h09);
    run_op(3'h5, 1'b0, 3'h0, 7'h09);
    run_op(3'h4, 1'b0, 3'h6, 7'h09);
    run_op(3'h0, 1'b1, 3'h0, 7'h09);
    for (int i = 0; i < 300; i++)
    begin
      r = $urandom;
      s = $urandom;
      if (s[31])
        setv(s[7:0], s[15:8], s[19:16], r[14:8]);
      run_op(r[2:0], r[3], r[6:4], r[14:8]);
    end
    // Reset mid-run clears acc and status, memory keeps its contents
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(bab_pkg::ADDR_ACC, 32'h0);
    rd_chk(bab_pkg::ADDR_STATUS, 32'h0);
    rd_chk(10'h200, {24'h0, m_mem[0]});
    close_out;
  end
endmodule
